// *** hw/dpm_block_ram.v ***
// dual-port 18 kbit block memory with optional output registers
// Overview of operation
// RULE1 - two independent ports share one array of memory cells
// RULE2 - each port acts on its own clock edge, polarity selectable
// RULE3 - port disabled: outputs hold and no cell is written; the output register still loads the latch when its enable is active
// RULE4 - write only with enable and write enable; output follows write mode
// RULE5 - enabled with write enable low performs a read onto the output
// RULE6 - output register captures latch when its enable is active
// RULE7 - output reset loads latches and parity with per-port value only
// RULE8 - output reset acts only on active edge with port enabled
// RULE9 - output reset unavailable when the output register is used
// RULE10 - width 1 to 36 selects depth; only upper address bits used
// RULE11 - cascade uses one bit width and 15-bit address, top bit selects
// RULE12 - data plus parity buses together equal the port width
// RULE13 - output holds cells read at last edge until next operation
// RULE14 - write shows new or old data, or holds, per mode
// RULE15 - upper chain input connects to lower chain output in cascade
// RULE16 - clock, enable, write, register enable, reset each invertible
// RULE17 - global reset loads output latches with initial values
// RULE18 - global reset leaves the memory contents unchanged
// RULE19 - surrounding logic should tie unused data and address inputs high
// RULE20 - address selects cells ADDR*W through (ADDR+1)*W-1
// RULE21 - write-first shows new data, read-first shows old data
// RULE22 - hold-output mode is not offered when cascaded
// RULE23 - output register adds one cycle of read latency
`timescale 1ns/1ps
`include "dpm_block_ram_map.vh"
module dpm_block_ram #(
	parameter [5:0] A_WIDTH = `DPM_W36,
	parameter [1:0] A_WRITE_MODE = `DPM_MODE_WRITE_FIRST,
	parameter [1:0] A_CASCADE = `DPM_CASC_NONE,
	parameter [0:0] A_DO_REG = 1'h0,
	parameter [35:0] A_INIT = `DPM_INIT_DEF,
	parameter [35:0] A_OUTPUT_RESET_VALUE = `DPM_OUTPUT_RESET_VALUE_DEF,
	parameter [0:0] A_INV_CLK = 1'h0,
	parameter [0:0] A_INV_EN = 1'h0,
	parameter [0:0] A_INV_WE = 1'h0,
	parameter [0:0] A_INV_OCE = 1'h0,
	parameter [0:0] A_INV_ORST = 1'h0,
	parameter [5:0] B_WIDTH = `DPM_W36,
	parameter [1:0] B_WRITE_MODE = `DPM_MODE_WRITE_FIRST,
	parameter [1:0] B_CASCADE = `DPM_CASC_NONE,
	parameter [0:0] B_DO_REG = 1'h0,
	parameter [35:0] B_INIT = `DPM_INIT_DEF,
	parameter [35:0] B_OUTPUT_RESET_VALUE = `DPM_OUTPUT_RESET_VALUE_DEF,
	parameter [0:0] B_INV_CLK = 1'h0,
	parameter [0:0] B_INV_EN = 1'h0,
	parameter [0:0] B_INV_WE = 1'h0,
	parameter [0:0] B_INV_OCE = 1'h0,
	parameter [0:0] B_INV_ORST = 1'h0
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire port_a_clk_in,
	input wire port_a_enable_in,
	input wire port_a_write_enable_in,
	input wire port_a_output_reg_clock_enable_in,
	input wire port_a_sync_output_reset_in,
	input wire [14:0] port_a_addr_in,
	input wire [31:0] port_a_data_in_bus_in,
	input wire [3:0] port_a_parity_in_bus_in,
	input wire port_a_chain_in_upper_in,
	output wire [31:0] port_a_data_out_bus_out,
	output wire [3:0] port_a_parity_out_bus_out,
	output wire port_a_chain_out_lower_out,
	input wire port_b_clk_in,
	input wire port_b_enable_in,
	input wire port_b_write_enable_in,
	input wire port_b_output_reg_clock_enable_in,
	input wire port_b_sync_output_reset_in,
	input wire [14:0] port_b_addr_in,
	input wire [31:0] port_b_data_in_bus_in,
	input wire [3:0] port_b_parity_in_bus_in,
	input wire port_b_chain_in_upper_in,
	output wire [31:0] port_b_data_out_bus_out,
	output wire [3:0] port_b_parity_out_bus_out,
	output wire port_b_chain_out_lower_out
);

// data cells of one word for a given port width
function [5:0] dpm_dbits;
	input [5:0] w;
	begin
		case (w)
		`DPM_W1: dpm_dbits = 6'h01;
		`DPM_W2: dpm_dbits = 6'h02;
		`DPM_W4: dpm_dbits = 6'h04;
		`DPM_W9: dpm_dbits = 6'h08;
		`DPM_W18: dpm_dbits = 6'h10;
		default: dpm_dbits = 6'h20;
		endcase
	end
endfunction

// parity cells of one word; none below width 9
function [3:0] dpm_pmask;
	input [5:0] w;
	begin
		case (w)
		`DPM_W9: dpm_pmask = 4'h1;
		`DPM_W18: dpm_pmask = 4'h3;
		`DPM_W36: dpm_pmask = 4'hf;
		default: dpm_pmask = 4'h0;
		endcase
	end
endfunction

function [31:0] dpm_dmask;
	input [5:0] w;
	begin
		dpm_dmask = 32'hffff_ffff >> (6'h20 - dpm_dbits(w)); // [RULE12]
	end
endfunction

// offset of the word inside its 32-cell row; low address bits drop
function [4:0] dpm_off;
	input [5:0] w;
	input [14:0] ad;
	reg [5:0] m;
	begin
		m = dpm_dbits(w) - 6'h01;
		dpm_off = ad[4:0] & ~m[4:0]; // [RULE10] [RULE20]
	end
endfunction

// pick the addressed word out of a row, as {parity, data}
function [35:0] dpm_pick;
	input [31:0] wd;
	input [3:0] pw;
	input [5:0] w;
	input [14:0] ad;
	reg [4:0] o;
	reg [31:0] d;
	reg [3:0] p;
	begin
		o = dpm_off(w, ad);
		d = (wd >> o) & dpm_dmask(w);
		p = (pw >> o[4:3]) & dpm_pmask(w);
		dpm_pick = {p, d}; // [RULE20]
	end
endfunction

// merge a written word into its row, as {parity, data}
function [35:0] dpm_merge;
	input [31:0] wd;
	input [3:0] pw;
	input [5:0] w;
	input [14:0] ad;
	input [35:0] nv;
	reg [4:0] o;
	reg [31:0] dm;
	reg [3:0] pm;
	begin
		o = dpm_off(w, ad);
		dm = dpm_dmask(w) << o;
		pm = dpm_pmask(w) << o[4:3];
		dpm_merge = {(pw & ~pm) | ((nv[35:32] << o[4:3]) & pm),
			(wd & ~dm) | ((nv[31:0] << o) & dm)}; // [RULE20]
	end
endfunction

// bits above the port width read as zero
function [35:0] dpm_trim;
	input [35:0] v;
	input [5:0] w;
	begin
		dpm_trim = {v[35:32] & dpm_pmask(w), v[31:0] & dpm_dmask(w)};
	end
endfunction

// init and reset values come at port width, parity above data
function [35:0] dpm_unpack;
	input [35:0] v;
	input [5:0] w;
	begin
		case (w)
		`DPM_W9: dpm_unpack = {3'h0, v[8], 24'h00_0000, v[7:0]};
		`DPM_W18: dpm_unpack = {2'h0, v[17:16], 16'h0000, v[15:0]};
		default: dpm_unpack = dpm_trim(v, w);
		endcase
	end
endfunction

// the cascade forbids hold-output mode; fall back to write-first
function [1:0] dpm_mode;
	input [1:0] m;
	input [1:0] c;
	begin
		if (c != `DPM_CASC_NONE && m == `DPM_MODE_NO_CHANGE)
			dpm_mode = `DPM_MODE_WRITE_FIRST; // [RULE22]
		else
			dpm_mode = m;
	end
endfunction

// does this block own the cascade half that the address selects
function dpm_owns;
	input [1:0] c;
	input [14:0] ad;
	begin
		case (c)
		`DPM_CASC_UPPER: dpm_owns = ad[`DPM_CASC_BIT]; // [RULE11]
		`DPM_CASC_LOWER: dpm_owns = ~ad[`DPM_CASC_BIT]; // [RULE11]
		default: dpm_owns = 1'b1;
		endcase
	end
endfunction

localparam [1:0] A_MODE = dpm_mode(A_WRITE_MODE, A_CASCADE);
localparam [1:0] B_MODE = dpm_mode(B_WRITE_MODE, B_CASCADE);

// shared cells; no reset, so the global reset never touches them
reg [31:0] mem_word [0:`DPM_ROWS-1]; // [RULE1] [RULE18]
reg [3:0] mem_par [0:`DPM_ROWS-1];

// pin clock edges are acted on only after the synchronisers have settled
reg [1:0] warm_r;
wire warm_done;
assign warm_done = (warm_r == `DPM_WARM_CYCLES);

always @(posedge ref_clk_in) begin
	if (!rst_n_in)
		warm_r <= 2'h0;
	else if (!warm_done)
		warm_r <= warm_r + 2'h1;
end

// ---- port a ----
reg a_ck1_r;
reg a_ck2_r;
reg a_ck3_r;
always @(posedge ref_clk_in) begin
	if (!rst_n_in) begin
		a_ck1_r <= 1'b0;
		a_ck2_r <= 1'b0;
		a_ck3_r <= 1'b0;
	end else begin
		a_ck1_r <= port_a_clk_in;
		a_ck2_r <= a_ck1_r;
		a_ck3_r <= a_ck2_r;
	end
end

wire a_act, a_en, a_we, a_oce, a_orst, a_wr;
wire [8:0] a_row;
wire [35:0] a_old, a_new, a_din;
assign a_act = warm_done & (A_INV_CLK ? (a_ck3_r & ~a_ck2_r) :
	(~a_ck3_r & a_ck2_r)); // [RULE2] [RULE16]
assign a_en = port_a_enable_in ^ A_INV_EN; // [RULE16]
assign a_we = port_a_write_enable_in ^ A_INV_WE; // [RULE16]
assign a_oce = port_a_output_reg_clock_enable_in ^ A_INV_OCE; // [RULE16]
assign a_orst = (port_a_sync_output_reset_in ^ A_INV_ORST) &
	~A_DO_REG; // [RULE9] [RULE16]
assign a_row = port_a_addr_in[`DPM_ROW_HI:`DPM_ROW_LO];
assign a_din = dpm_trim({port_a_parity_in_bus_in,
	port_a_data_in_bus_in}, A_WIDTH); // [RULE12]
assign a_old = dpm_pick(mem_word[a_row], mem_par[a_row], A_WIDTH,
	port_a_addr_in);
assign a_wr = a_act & a_en & a_we &
	dpm_owns(A_CASCADE, port_a_addr_in); // [RULE3] [RULE4]
assign a_new = dpm_merge(mem_word[a_row], mem_par[a_row], A_WIDTH,
	port_a_addr_in, a_din);

reg [35:0] a_lat_r;
reg a_hi_r;
always @(posedge ref_clk_in) begin
	if (!rst_n_in) begin
		a_lat_r <= dpm_unpack(A_INIT, A_WIDTH); // [RULE17]
		a_hi_r <= 1'b0;
	end else if (a_act && a_en) begin // [RULE3] [RULE8]
		a_hi_r <= port_a_addr_in[`DPM_CASC_BIT]; // [RULE11]
		if (a_orst)
			a_lat_r <= dpm_unpack(A_OUTPUT_RESET_VALUE, A_WIDTH); // [RULE7]
		else if (!a_we)
			a_lat_r <= a_old; // [RULE5] [RULE13]
		else if (A_MODE == `DPM_MODE_WRITE_FIRST)
			a_lat_r <= a_din; // [RULE14] [RULE21]
		else if (A_MODE == `DPM_MODE_READ_FIRST)
			a_lat_r <= a_old; // [RULE14] [RULE21]
	end
end

// the upper block shows the lower block's bit for low addresses
wire [35:0] a_view;
assign a_view = (A_CASCADE == `DPM_CASC_UPPER && !a_hi_r) ?
	{32'h0000_0000, 3'h0, port_a_chain_in_upper_in} : a_lat_r; // [RULE15]

reg [35:0] a_oreg_r;
always @(posedge ref_clk_in) begin
	if (!rst_n_in)
		a_oreg_r <= dpm_unpack(A_INIT, A_WIDTH); // [RULE17]
	else if (A_DO_REG && a_act && a_oce)
		a_oreg_r <= a_view; // [RULE6] [RULE23]
end

assign port_a_data_out_bus_out = A_DO_REG ? a_oreg_r[31:0] : a_view[31:0];
assign port_a_parity_out_bus_out = A_DO_REG ? a_oreg_r[35:32] :
	a_view[35:32];
assign port_a_chain_out_lower_out = (A_CASCADE == `DPM_CASC_LOWER) &
	a_lat_r[0]; // [RULE15]

// ---- port b ----
reg b_ck1_r;
reg b_ck2_r;
reg b_ck3_r;
always @(posedge ref_clk_in) begin
	if (!rst_n_in) begin
		b_ck1_r <= 1'b0;
		b_ck2_r <= 1'b0;
		b_ck3_r <= 1'b0;
	end else begin
		b_ck1_r <= port_b_clk_in;
		b_ck2_r <= b_ck1_r;
		b_ck3_r <= b_ck2_r;
	end
end

wire b_act, b_en, b_we, b_oce, b_orst, b_wr;
wire [8:0] b_row;
wire [35:0] b_old, b_new, b_din;
wire [31:0] b_base_word;
wire [3:0] b_base_par;
assign b_act = warm_done & (B_INV_CLK ? (b_ck3_r & ~b_ck2_r) :
	(~b_ck3_r & b_ck2_r)); // [RULE2] [RULE16]
assign b_en = port_b_enable_in ^ B_INV_EN; // [RULE16]
assign b_we = port_b_write_enable_in ^ B_INV_WE; // [RULE16]
assign b_oce = port_b_output_reg_clock_enable_in ^ B_INV_OCE; // [RULE16]
assign b_orst = (port_b_sync_output_reset_in ^ B_INV_ORST) &
	~B_DO_REG; // [RULE9] [RULE16]
assign b_row = port_b_addr_in[`DPM_ROW_HI:`DPM_ROW_LO];
assign b_din = dpm_trim({port_b_parity_in_bus_in,
	port_b_data_in_bus_in}, B_WIDTH); // [RULE12]
assign b_old = dpm_pick(mem_word[b_row], mem_par[b_row], B_WIDTH,
	port_b_addr_in);
assign b_wr = b_act & b_en & b_we &
	dpm_owns(B_CASCADE, port_b_addr_in); // [RULE3] [RULE4]
// both ports writing one row: merge b over a so disjoint cells both land
assign b_base_word = (a_wr && a_row == b_row) ? a_new[31:0] :
	mem_word[b_row];
assign b_base_par = (a_wr && a_row == b_row) ? a_new[35:32] :
	mem_par[b_row];
assign b_new = dpm_merge(b_base_word, b_base_par, B_WIDTH,
	port_b_addr_in, b_din);

reg [35:0] b_lat_r;
reg b_hi_r;
always @(posedge ref_clk_in) begin
	if (!rst_n_in) begin
		b_lat_r <= dpm_unpack(B_INIT, B_WIDTH); // [RULE17]
		b_hi_r <= 1'b0;
	end else if (b_act && b_en) begin // [RULE3] [RULE8]
		b_hi_r <= port_b_addr_in[`DPM_CASC_BIT]; // [RULE11]
		if (b_orst)
			b_lat_r <= dpm_unpack(B_OUTPUT_RESET_VALUE, B_WIDTH); // [RULE7]
		else if (!b_we)
			b_lat_r <= b_old; // [RULE5] [RULE13]
		else if (B_MODE == `DPM_MODE_WRITE_FIRST)
			b_lat_r <= b_din; // [RULE14] [RULE21]
		else if (B_MODE == `DPM_MODE_READ_FIRST)
			b_lat_r <= b_old; // [RULE14] [RULE21]
	end
end

wire [35:0] b_view;
assign b_view = (B_CASCADE == `DPM_CASC_UPPER && !b_hi_r) ?
	{32'h0000_0000, 3'h0, port_b_chain_in_upper_in} : b_lat_r; // [RULE15]

reg [35:0] b_oreg_r;
always @(posedge ref_clk_in) begin
	if (!rst_n_in)
		b_oreg_r <= dpm_unpack(B_INIT, B_WIDTH); // [RULE17]
	else if (B_DO_REG && b_act && b_oce)
		b_oreg_r <= b_view; // [RULE6] [RULE23]
end

assign port_b_data_out_bus_out = B_DO_REG ? b_oreg_r[31:0] : b_view[31:0];
assign port_b_parity_out_bus_out = B_DO_REG ? b_oreg_r[35:32] :
	b_view[35:32];
assign port_b_chain_out_lower_out = (B_CASCADE == `DPM_CASC_LOWER) &
	b_lat_r[0]; // [RULE15]

// ---- shared array write ----
// a row written by both ports on one edge keeps b's cells where they
// overlap; overlapping writes are a user conflict anyway
always @(posedge ref_clk_in) begin
	if (a_wr && !(b_wr && a_row == b_row)) begin
		mem_word[a_row] <= a_new[31:0]; // [RULE4] [RULE20]
		mem_par[a_row] <= a_new[35:32];
	end
	if (b_wr) begin
		mem_word[b_row] <= b_new[31:0]; // [RULE4] [RULE20]
		mem_par[b_row] <= b_new[35:32];
	end
end

endmodule // dpm_block_ram

// *** hw/dpm_block_ram_map.vh ***
// constants for the dual-port block memory
`ifndef DPM_BLOCK_RAM_MAP_VH
`define DPM_BLOCK_RAM_MAP_VH
// write modes
`define DPM_MODE_WRITE_FIRST 2'h0
`define DPM_MODE_READ_FIRST 2'h1
`define DPM_MODE_NO_CHANGE 2'h2
// cascade roles
`define DPM_CASC_NONE 2'h0
`define DPM_CASC_LOWER 2'h1
`define DPM_CASC_UPPER 2'h2
// array geometry: 512 rows of 32 data plus 4 parity cells
`define DPM_ROWS 512
`define DPM_ROW_HI 13
`define DPM_ROW_LO 5
`define DPM_CASC_BIT 14
// port widths
`define DPM_W1 6'h01
`define DPM_W2 6'h02
`define DPM_W4 6'h04
`define DPM_W9 6'h09
`define DPM_W18 6'h12
`define DPM_W36 6'h24
// reset values
`define DPM_INIT_DEF 36'h0_0000_0000
`define DPM_OUTPUT_RESET_VALUE_DEF 36'h0_0000_0000
// cycles after reset before pin clock edges are trusted
`define DPM_WARM_CYCLES 2'h3
`endif

// *** tb/dpm_block_ram_sva.sv ***
// port checker for the dual-port block memory
`timescale 1ns/1ps
module dpm_block_ram_sva #(
	parameter [35:0] A_INIT = 36'h0_0000_0000,
	parameter [35:0] A_OUTPUT_RESET_VALUE = 36'h0_0000_0000,
	parameter [35:0] B_INIT = 36'h0_0000_0000,
	parameter [1:0] A_WRITE_MODE = 2'h0
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire port_a_clk_in,
	input wire port_a_enable_in,
	input wire port_a_write_enable_in,
	input wire port_a_sync_output_reset_in,
	input wire [31:0] port_a_data_in_bus_in,
	input wire [3:0] port_a_parity_in_bus_in,
	input wire [31:0] port_a_data_out_bus_out,
	input wire [3:0] port_a_parity_out_bus_out,
	input wire port_a_chain_out_lower_out,
	input wire port_b_clk_in,
	input wire port_b_output_reg_clock_enable_in,
	input wire [31:0] port_b_data_out_bus_out,
	input wire [3:0] port_b_parity_out_bus_out,
	input wire port_b_chain_out_lower_out
);
	wire [35:0] ao = {port_a_parity_out_bus_out, port_a_data_out_bus_out};
	wire [35:0] bo = {port_b_parity_out_bus_out, port_b_data_out_bus_out};
	wire [35:0] ai = {port_a_parity_in_bus_in, port_a_data_in_bus_in};
	wire a_go = port_a_clk_in;
	wire a_en = port_a_enable_in;
	reg [3:0] a_idle_r;
	reg [3:0] b_idle_r;
	// cycles since the pin clock was last high; outputs may only move near it
	always @(posedge ref_clk_in) begin
		if (!rst_n_in || port_a_clk_in)
			a_idle_r <= 4'h0;
		else if (a_idle_r != 4'hF)
			a_idle_r <= a_idle_r + 4'h1;
		if (!rst_n_in || port_b_clk_in)
			b_idle_r <= 4'h0;
		else if (b_idle_r != 4'hF)
			b_idle_r <= b_idle_r + 4'h1;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_hold_disabled: assert property ($rose(a_go) && !a_en |=>
		$stable(ao) [*6]) else $error("output moved while disabled");
	a_write_through: assert property (A_WRITE_MODE == 2'h0 &&
		$rose(a_go) && a_en &&
		port_a_write_enable_in && !port_a_sync_output_reset_in |->
		##[1:6] ao == ai) else $error("write data not shown");
	a_write_hold: assert property (A_WRITE_MODE == 2'h2 &&
		$rose(a_go) && a_en && port_a_write_enable_in &&
		!port_a_sync_output_reset_in |=> $stable(ao) [*6])
		else $error("output moved on hold-mode write");
	a_reset_load: assert property ($rose(a_go) && a_en &&
		port_a_sync_output_reset_in |-> ##[1:6] ao == A_OUTPUT_RESET_VALUE)
		else $error("reset value not loaded");
	a_reg_hold: assert property ($rose(port_b_clk_in) &&
		!port_b_output_reg_clock_enable_in |=> $stable(bo) [*6])
		else $error("output register moved without enable");
	a_init_load: assert property ($rose(rst_n_in) |->
		ao == A_INIT && bo[8:0] == B_INIT[7:0] && bo[32] == B_INIT[8])
		else $error("init value missing");
	a_width_zero: assert property ({bo[35:33], bo[31:8]} ==
		{3'h0, 24'h00_0000})
		else $error("unused output bits set");
	a_chain_idle: assert property (!port_a_chain_out_lower_out &&
		!port_b_chain_out_lower_out) else $error("chain out active");
	a_quiet_a: assert property (a_idle_r > 4'h3 |-> $stable(ao))
		else $error("port a output moved without its clock");
	a_quiet_b: assert property (b_idle_r > 4'h3 |-> $stable(bo))
		else $error("port b output moved without its clock");
	c_write: cover property ($rose(a_go) && a_en && port_a_write_enable_in);
	c_reset: cover property ($rose(a_go) && port_a_sync_output_reset_in);
	c_reg: cover property ($rose(port_b_clk_in) &&
		port_b_output_reg_clock_enable_in);
	c_hold: cover property (A_WRITE_MODE == 2'h2 && $rose(a_go) && a_en &&
		port_a_write_enable_in);
endmodule // dpm_block_ram_sva

bind dpm_block_ram dpm_block_ram_sva #(.A_INIT(A_INIT), .A_OUTPUT_RESET_VALUE(A_OUTPUT_RESET_VALUE),
	.B_INIT(B_INIT), .A_WRITE_MODE(A_WRITE_MODE)) u_sva (.*);

// *** tb/dpm_port_drv.sv ***
// model of the fabric logic that drives one memory port
`timescale 1ns/1ps
module dpm_port_drv (
	input wire ref_clk_in,
	output reg clk_out,
	output reg en_out,
	output reg we_out,
	output reg oce_out,
	output reg rst_out,
	output reg [14:0] addr_out,
	output reg [31:0] data_out,
	output reg [3:0] par_out
);
	initial begin
		{clk_out, en_out, we_out, oce_out, rst_out} = 5'h00;
		{addr_out, par_out, data_out} = {51{1'b1}};
	end
	// c is {enable, write, reset, register enable}; pin phases of 4 cycles
	task op(input [3:0] c, input [14:0] a, input [35:0] d);
		@(posedge ref_clk_in);
		{en_out, we_out, rst_out, oce_out} <= c;
		addr_out <= a;
		{par_out, data_out} <= d;
		clk_out <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		clk_out <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		{en_out, we_out, rst_out, oce_out} <= 4'h0;
		// a released bus shows the inverse, never the last value
		{par_out, data_out} <= ~d;
		#1;
	endtask
endmodule // dpm_port_drv

// *** tb/test_dpm_block_ram.sv ***
// self-checking bench for the dual-port block memory
`timescale 1ns/1ps
module test_dpm_block_ram;
	localparam [35:0] AI = 36'h5_1234_5678;
	localparam [35:0] AS = 36'hA_5A5A_C3C3;
	localparam [35:0] BI = 36'h0_0000_01A5;
	localparam [35:0] W0 = 36'h5_1122_3344;
	localparam [35:0] W1 = 36'h1_11EE_3344;
	localparam [5:0] BW = 6'h09;
	localparam [1:0] BM = 2'h1;
	localparam [0:0] BR = 1'h1;
	localparam [35:0] BS = 36'h0_0000_0155;
	localparam [1:0] NC = 2'h2;
	reg clk;
	reg rst_n = 1'b0;
	integer fail_count = 0;
	integer comparisons = 0;
	reg [2:0] k;
	wire a_clk, a_en, a_we, a_oce, a_rst, b_clk, b_en, b_we, b_oce, b_rst;
	wire [14:0] a_ad, b_ad;
	wire [31:0] a_di, b_di, a_do, b_do;
	wire [3:0] a_pi, b_pi, a_po, b_po;
	wire [35:0] ao = {a_po, a_do};
	wire [35:0] bo = {b_po, b_do};
	wire a_co, b_co, ha_co, hb_co;
	wire [31:0] h_do;
	wire [3:0] h_po;
	wire [35:0] ho = {h_po, h_do};
	dpm_port_drv pa (.ref_clk_in(clk), .clk_out(a_clk), .en_out(a_en),
		.we_out(a_we), .oce_out(a_oce), .rst_out(a_rst), .addr_out(a_ad),
		.data_out(a_di), .par_out(a_pi));
	dpm_port_drv pb (.ref_clk_in(clk), .clk_out(b_clk), .en_out(b_en),
		.we_out(b_we), .oce_out(b_oce), .rst_out(b_rst), .addr_out(b_ad),
		.data_out(b_di), .par_out(b_pi));
	dpm_block_ram #(.A_INIT(AI), .A_OUTPUT_RESET_VALUE(AS), .B_WIDTH(BW),
		.B_WRITE_MODE(BM), .B_DO_REG(BR), .B_INIT(BI),
		.B_OUTPUT_RESET_VALUE(BS)) dut (
		.ref_clk_in(clk), .rst_n_in(rst_n),
		.port_a_clk_in(a_clk), .port_a_enable_in(a_en),
		.port_a_write_enable_in(a_we),
		.port_a_output_reg_clock_enable_in(a_oce),
		.port_a_sync_output_reset_in(a_rst), .port_a_addr_in(a_ad),
		.port_a_data_in_bus_in(a_di), .port_a_parity_in_bus_in(a_pi),
		.port_a_chain_in_upper_in(ha_co), .port_a_data_out_bus_out(a_do),
		.port_a_parity_out_bus_out(a_po),
		.port_a_chain_out_lower_out(a_co),
		.port_b_clk_in(b_clk), .port_b_enable_in(b_en),
		.port_b_write_enable_in(b_we),
		.port_b_output_reg_clock_enable_in(b_oce),
		.port_b_sync_output_reset_in(b_rst), .port_b_addr_in(b_ad),
		.port_b_data_in_bus_in(b_di), .port_b_parity_in_bus_in(b_pi),
		.port_b_chain_in_upper_in(hb_co), .port_b_data_out_bus_out(b_do),
		.port_b_parity_out_bus_out(b_po),
		.port_b_chain_out_lower_out(b_co));
	// twin on the same pins whose port a keeps its output during writes
	dpm_block_ram #(.A_WRITE_MODE(NC), .A_INIT(AI), .A_OUTPUT_RESET_VALUE(AS),
		.B_WIDTH(BW), .B_WRITE_MODE(BM), .B_DO_REG(BR), .B_INIT(BI),
		.B_OUTPUT_RESET_VALUE(BS)) dut_hold (
		.ref_clk_in(clk), .rst_n_in(rst_n),
		.port_a_clk_in(a_clk), .port_a_enable_in(a_en),
		.port_a_write_enable_in(a_we),
		.port_a_output_reg_clock_enable_in(a_oce),
		.port_a_sync_output_reset_in(a_rst), .port_a_addr_in(a_ad),
		.port_a_data_in_bus_in(a_di), .port_a_parity_in_bus_in(a_pi),
		.port_a_chain_in_upper_in(a_co), .port_a_data_out_bus_out(h_do),
		.port_a_parity_out_bus_out(h_po),
		.port_a_chain_out_lower_out(ha_co),
		.port_b_clk_in(b_clk), .port_b_enable_in(b_en),
		.port_b_write_enable_in(b_we),
		.port_b_output_reg_clock_enable_in(b_oce),
		.port_b_sync_output_reset_in(b_rst), .port_b_addr_in(b_ad),
		.port_b_data_in_bus_in(b_di), .port_b_parity_in_bus_in(b_pi),
		.port_b_chain_in_upper_in(b_co), .port_b_data_out_bus_out(),
		.port_b_parity_out_bus_out(),
		.port_b_chain_out_lower_out(hb_co));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function [35:0] bexp(input [1:0] i);
		bexp = {3'h0, W0[32 + i], 24'h00_0000, W0[8 * i +: 8]};
	endfunction
	task chk(input [35:0] got, input [35:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task complete_run;
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count = fail_count + 1;
		complete_run;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(ao, AI);
		chk(bo, 36'h1_0000_00A5);
		repeat (5) @(posedge clk);
		pa.op(4'hC, 15'h0060, W0);
		chk(ao, W0);
		chk(ho, AI);
		pa.op(4'h4, 15'h0060, 36'h0_DEAD_BEEF);
		chk(ao, W0);
		// the register shows the previous read until the next enabled edge
		for (k = 3'h0; k < 3'h4; k = k + 3'h1) begin
			pb.op(4'h9, {6'h00, 4'h3, k[1:0], 3'h0}, 36'h0);
			if (k != 3'h0) chk(bo, bexp(k[1:0] - 2'h1));
			pb.op(4'h9, {6'h00, 4'h3, k[1:0], 3'h0}, 36'h0);
			chk(bo, bexp(k[1:0]));
		end
		pb.op(4'hD, 15'h0070, 36'h0_0000_00EE);
		pb.op(4'h9, 15'h0070, 36'h0);
		chk(bo, bexp(2'h2));
		pb.op(4'h9, 15'h0070, 36'h0);
		chk(bo, 36'h0_0000_00EE);
		pa.op(4'h8, 15'h0060, 36'h0);
		chk(ao, W1);
		chk(ho, W1);
		pa.op(4'h2, 15'h0060, 36'h0);
		chk(ao, W1);
		pa.op(4'hA, 15'h0060, 36'h0);
		chk(ao, AS);
		pa.op(4'h8, 15'h0060, 36'h0);
		chk(ao, W1);
		pb.op(4'hB, 15'h0068, 36'h0);
		pb.op(4'h9, 15'h0068, 36'h0);
		chk(bo, bexp(2'h1));
		pb.op(4'h8, 15'h0060, 36'h0);
		chk(bo, bexp(2'h1));
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(ao, AI);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		pa.op(4'h8, 15'h0060, 36'h0);
		chk(ao, W1);
		complete_run;
	end
endmodule // test_dpm_block_ram
